//--- logic/ccs_params.svh
// Purpose: offsets, field positions, reset values and limits of the bank
// Assumes: byte-wide register port, 200 MHz sys_clk
// Notes: definitions only
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
`define CCS_ADDR_SETPOINT_LOW 8'h0C
`define CCS_ADDR_SETPOINT_HIGH 8'h0D
`define CCS_ADDR_CC_STATUS 8'h21
`define CCS_ADDR_FAULT_SUMMARY 8'h78
`define CCS_ADDR_CONTROL 8'h81
`define CCS_RST_SETPOINT_LOW 8'h58
`define CCS_RST_SETPOINT_HIGH 4'h2
`define CCS_RST_CONTROL 8'h01
`define CCS_RST_FAULT 8'h00
`define CCS_SETPOINT_HIGH_MASK 8'h0F
`define CCS_CONTROL_MASK 8'h03
`define CCS_CTRL_ENABLE_BIT 0
`define CCS_CTRL_DISCHARGE_BIT 1
`define CCS_CC_ACTIVE_BIT 6
`define CCS_FAULT_BUSY_BIT 7
`define CCS_FAULT_OFF_BIT 6
`define CCS_FAULT_OV_BIT 5
`define CCS_FAULT_OC_BIT 4
`define CCS_FAULT_UV_BIT 3
`define CCS_FAULT_TEMP_BIT 2
`define CCS_FAULT_CML_BIT 1
`define CCS_FAULT_OTHER_BIT 0
`define CCS_ILIM_LAST_STEP_CODE 8'h8B
`define CCS_ILIM_MAX_UV 17'd70000
`define CCS_ILIM_STEP_UV 17'd500
`define CCS_VOUT_STEP20_MV 16'd20
`define CCS_VOUT_STEP10_MV 16'd10
`define CCS_VOUT_MIN20_MV 16'd3300
`define CCS_VOUT_MIN10_MV 16'd1000
`define CCS_VOUT_MAX_MV 16'd48000
`endif

//--- logic/ccs_pkg.sv
// Purpose: shared types of the converter register bank
// Assumes: nothing
// Notes: constants live in ccs_params.svh
package ccs_pkg;
  typedef struct packed {
    logic busy;
    logic unit_off;
    logic output_overvoltage;
    logic output_overcurrent;
    logic input_undervoltage;
    logic temperature_fault;
    logic comm_logic_memory_fault;
    logic other_fault;
  } ccs_fault_s;
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccs_req_s;
  typedef enum logic [2:0] {
    CCS_IDLE = 3'b001,
    CCS_READ = 3'b010,
    CCS_WRITE = 3'b100
  } ccs_state_e;
endpackage : ccs_pkg

//--- logic/ccs_ilim_map.sv
// Purpose: current-limit code to sense threshold in microvolts
// Assumes: code is the threshold register value
// Notes: registered output
`timescale 1ns/10ps
`include "ccs_params.svh"
module ccs_ilim_map (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] current_limit_threshold,
  output logic [16:0] threshold_uv
);
  logic [16:0] threshold_uv_reg;
  logic [16:0] threshold_uv_next;
  // half-millivolt steps, clamped above the last step code
  always_comb begin
    if (current_limit_threshold > `CCS_ILIM_LAST_STEP_CODE) begin
      threshold_uv_next = `CCS_ILIM_MAX_UV; // [RL1]
    end else begin
      threshold_uv_next =
        17'(current_limit_threshold * `CCS_ILIM_STEP_UV); // [RL2]
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      threshold_uv_reg <= 17'h0_0000;
    end else begin
      threshold_uv_reg <= threshold_uv_next;
    end
  end
  assign threshold_uv = threshold_uv_reg;
  AST_ILIM_SAT: assert property (@(posedge sys_clk) // [RL1]
    disable iff (reset) !$past(reset)
    && $past(current_limit_threshold) >= 8'hC1
    |-> threshold_uv == 17'd70000)
    else $error("saturated code not at maximum");
  AST_ILIM_STEP: assert property (@(posedge sys_clk) // [RL2]
    disable iff (reset) !$past(reset)
    && $past(current_limit_threshold) == 8'h8B
    |-> threshold_uv == 17'd69500)
    else $error("last step code wrong");
endmodule : ccs_ilim_map

//--- logic/ccs_vout_target.sv
// Purpose: setpoint code to clamped output target in millivolts
// Assumes: feedback_divider_select high picks 20 mV steps
// Notes: registered output
`timescale 1ns/10ps
`include "ccs_params.svh"
module ccs_vout_target (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic feedback_divider_select,
  input wire logic [11:0] setpoint_code,
  output logic [15:0] target_mv
);
  logic [15:0] target_mv_reg;
  logic [15:0] target_mv_next;
  logic [31:0] raw_mv;
  logic [15:0] lo_mv;
  always_comb begin
    raw_mv = feedback_divider_select ?
      32'(setpoint_code) * 32'(`CCS_VOUT_STEP20_MV) :
      32'(setpoint_code) * 32'(`CCS_VOUT_STEP10_MV); // [RL4]
    lo_mv = feedback_divider_select ? `CCS_VOUT_MIN20_MV : `CCS_VOUT_MIN10_MV;
    if (raw_mv < 32'(lo_mv)) begin
      target_mv_next = lo_mv; // [RL5]
    end else if (raw_mv > 32'(`CCS_VOUT_MAX_MV)) begin
      target_mv_next = `CCS_VOUT_MAX_MV; // [RL5]
    end else begin
      target_mv_next = raw_mv[15:0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      target_mv_reg <= 16'h0000;
    end else begin
      target_mv_reg <= target_mv_next;
    end
  end
  assign target_mv = target_mv_reg;
  AST_VOUT_BOUNDS: assert property (@(posedge sys_clk) // [RL5]
    disable iff (reset) $past(reset) == 1'b0
    |-> target_mv <= 16'd48000
    && target_mv >= ($past(feedback_divider_select) ? 16'd3300 : 16'd1000))
    else $error("target out of bounds");
  AST_VOUT_STEP: assert property (@(posedge sys_clk) // [RL4]
    disable iff (reset) !$past(reset) && $past(feedback_divider_select)
    && $past(setpoint_code) == 12'd1000
    |-> target_mv == 16'd20000)
    else $error("20 mV step wrong");
endmodule : ccs_vout_target

//--- logic/ccs_regs.sv
// Purpose: converter configuration and status register bank
// Assumes: byte-wide synchronous register port, one access per cycle
// Notes: read data registered one cycle after the read strobe
// Function
// RL1 - threshold codes 0xC1 to 0xFF select the 70 mV maximum
// RL2 - half-millivolt steps per code up to 69.5 mV at 0x8B
// RL3 - setpoint is low byte plus high register low nibble
// RL4 - setpoint step 20 mV or 10 mV by feedback divider select
// RL5 - target bounded 3.3 V or 1 V low, 48 V high
// RL6 - reset loads setpoint low 0x58 and high nibble 0x2
// RL7 - unimplemented bits ignore writes and read zero
// RL8 - status bit 6 shows constant-current limiting live, read only
// RL9 - fault bit 7 follows busy
// RL10 - fault bit 6 set while off or not supplying output
// RL11 - fault bits 5..2 overvoltage, overcurrent, undervoltage, temperature
// RL12 - fault bit 1 flags communication, logic or memory event
// RL13 - fault bit 0 flags any other fault or warning
// RL14 - fault byte read only, resets to 0x00
// RL15 - control bit 1 requests output discharge, resets 0
// RL16 - control bit 0 enables the power stage
// RL17 - control register resets to 0x01
// RL18 - byte access, device decodes byte address
`timescale 1ns/10ps
`include "ccs_params.svh"
module ccs_regs (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] current_limit_threshold,
  input wire logic feedback_divider_select,
  input wire logic constant_current_active,
  input wire ccs_pkg::ccs_fault_s fault_in,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic output_discharge_request,
  output logic power_stage_enable_b,
  output logic [16:0] current_limit_threshold_uv,
  output logic [15:0] vout_target_mv,
  output logic [11:0] output_setpoint
);
  ////////////////////////////////////////////////////////////////////////////
  ccs_pkg::ccs_req_s req;
  ccs_pkg::ccs_state_e state_reg;
  ccs_pkg::ccs_state_e state_next;
  logic [7:0] setpoint_low_reg;
  logic [7:0] setpoint_low_next;
  logic [3:0] setpoint_high_reg;
  logic [3:0] setpoint_high_next;
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [7:0] fault_reg;
  logic [7:0] fault_next;
  logic cc_reg;
  logic cc_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic discharge_reg;
  logic enable_reg;
  logic [11:0] setpoint_out_reg;

  function automatic logic [7:0] read_mux(
    input logic [7:0] addr,
    input logic [7:0] sp_low,
    input logic [3:0] sp_high,
    input logic cc,
    input logic [7:0] fault,
    input logic [7:0] ctrl
  );
    logic [7:0] val;
    val = 8'h00; // [RL7]
    case (addr) // [RL18]
      `CCS_ADDR_SETPOINT_LOW: val = sp_low;
      `CCS_ADDR_SETPOINT_HIGH: val = {4'h0, sp_high}; // [RL7]
      `CCS_ADDR_CC_STATUS: val = 8'(cc) << `CCS_CC_ACTIVE_BIT; // [RL8]
      `CCS_ADDR_FAULT_SUMMARY: val = fault;
      `CCS_ADDR_CONTROL: val = ctrl & `CCS_CONTROL_MASK; // [RL7]
      default: val = 8'h00;
    endcase
    return val;
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////////
  // access sequencing
  always_comb begin
    req = '{wr_en: reg_wr_en, rd_en: reg_rd_en, addr: reg_addr,
            wdata: reg_wdata};
    if (req.wr_en) begin
      state_next = ccs_pkg::CCS_WRITE;
    end else if (req.rd_en) begin
      state_next = ccs_pkg::CCS_READ;
    end else begin
      state_next = ccs_pkg::CCS_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers
  always_comb begin
    setpoint_low_next = setpoint_low_reg;
    setpoint_high_next = setpoint_high_reg;
    control_next = control_reg;
    if (req.wr_en) begin
      case (req.addr) // [RL18]
        `CCS_ADDR_SETPOINT_LOW: setpoint_low_next = req.wdata; // [RL3]
        `CCS_ADDR_SETPOINT_HIGH: setpoint_high_next = req.wdata[3:0]; // [RL3]
        `CCS_ADDR_CONTROL: control_next = req.wdata & `CCS_CONTROL_MASK; // [RL7]
        default: control_next = control_reg; // [RL7]
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status capture and read data
  always_comb begin
    fault_next = fault_in; // [RL9] [RL10] [RL11] [RL12] [RL13]
    cc_next = constant_current_active; // [RL8]
    rvalid_next = req.rd_en && !req.wr_en;
    rdata_next = rdata_reg;
    case (state_next)
      ccs_pkg::CCS_READ: rdata_next = read_mux(req.addr, setpoint_low_reg,
        setpoint_high_reg, cc_reg, fault_reg, control_reg);
      ccs_pkg::CCS_WRITE: rdata_next = rdata_reg;
      ccs_pkg::CCS_IDLE: rdata_next = rdata_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ccs_pkg::CCS_IDLE;
      setpoint_low_reg <= `CCS_RST_SETPOINT_LOW; // [RL6]
      setpoint_high_reg <= `CCS_RST_SETPOINT_HIGH; // [RL6]
      control_reg <= `CCS_RST_CONTROL; // [RL17]
      fault_reg <= `CCS_RST_FAULT; // [RL14]
      cc_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      discharge_reg <= 1'b0;
      enable_reg <= 1'b1;
      setpoint_out_reg <= {`CCS_RST_SETPOINT_HIGH, `CCS_RST_SETPOINT_LOW};
    end else begin
      state_reg <= state_next;
      setpoint_low_reg <= setpoint_low_next;
      setpoint_high_reg <= setpoint_high_next;
      control_reg <= control_next;
      fault_reg <= fault_next;
      cc_reg <= cc_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      discharge_reg <= control_next[`CCS_CTRL_DISCHARGE_BIT]; // [RL15]
      enable_reg <= control_next[`CCS_CTRL_ENABLE_BIT]; // [RL16]
      setpoint_out_reg <= {setpoint_high_next, setpoint_low_next}; // [RL3]
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign output_discharge_request = discharge_reg;
  assign power_stage_enable_b = enable_reg;
  assign output_setpoint = setpoint_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  ccs_ilim_map u_ilim (
    .sys_clk(sys_clk),
    .reset(reset),
    .current_limit_threshold(current_limit_threshold),
    .threshold_uv(current_limit_threshold_uv)
  );

  ccs_vout_target u_vout (
    .sys_clk(sys_clk),
    .reset(reset),
    .feedback_divider_select(feedback_divider_select),
    .setpoint_code(setpoint_out_reg),
    .target_mv(vout_target_mv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  AST_RESET_VALUES: assert property (@(posedge sys_clk) // [RL6]
    $past(reset) |-> output_setpoint == 12'h258 && power_stage_enable_b
    && !output_discharge_request)
    else $error("reset values wrong");
  AST_CTRL_RESET: assert property (@(posedge sys_clk) // [RL17]
    $past(reset) |-> control_reg == 8'h01 && fault_reg == 8'h00)
    else $error("control or fault reset wrong");
  ////////////////////////////////////////////////////////////////////////////
  // read path
  AST_UNIMPL_ZERO: assert property (@(posedge sys_clk) // [RL7]
    disable iff (reset) reg_rd_en && !reg_wr_en && reg_addr == 8'h0D
    |=> reg_rvalid && reg_rdata[7:4] == 4'h0)
    else $error("unimplemented bits not zero");
  AST_CTRL_READ: assert property (@(posedge sys_clk) // [RL7]
    disable iff (reset) reg_rd_en && !reg_wr_en && reg_addr == 8'h81
    |=> reg_rdata[7:2] == 6'h00)
    else $error("control unimplemented bits not zero");
  AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk) // [RL7]
    disable iff (reset) reg_rd_en && !reg_wr_en
    && !(reg_addr inside {8'h0C, 8'h0D, 8'h21, 8'h78, 8'h81})
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CC_READ: assert property (@(posedge sys_clk) // [RL8]
    disable iff (reset) reg_rd_en && !reg_wr_en && reg_addr == 8'h21
    |=> reg_rdata == {1'b0, $past(cc_reg), 6'h00})
    else $error("cc status read wrong");
  AST_BUSY_BIT: assert property (@(posedge sys_clk) // [RL9]
    disable iff (reset) reg_rd_en && !reg_wr_en && reg_addr == 8'h78
    |=> reg_rdata[7] == $past(fault_reg[7]))
    else $error("busy bit read wrong");
  AST_FAULT_READ: assert property (@(posedge sys_clk) // [RL14]
    disable iff (reset) reg_rd_en && !reg_wr_en && reg_addr == 8'h78
    |=> reg_rdata == $past(fault_reg))
    else $error("fault byte read wrong");
  AST_RVALID_READ: assert property (@(posedge sys_clk) // [RL18]
    disable iff (reset) reg_rd_en && !reg_wr_en |=> reg_rvalid)
    else $error("read not answered");
  AST_RVALID_IDLE: assert property (@(posedge sys_clk) // [RL18]
    disable iff (reset) !(reg_rd_en && !reg_wr_en) |=> !reg_rvalid)
    else $error("read valid without read");
  AST_RVALID_STATE: assert property (@(posedge sys_clk) // [RL18]
    disable iff (reset) reg_rvalid == (state_reg == ccs_pkg::CCS_READ))
    else $error("read valid and state disagree");
  AST_RDATA_HOLD: assert property (@(posedge sys_clk) // [RL18]
    disable iff (reset) !(reg_rd_en && !reg_wr_en)
    |=> $stable(reg_rdata))
    else $error("read data changed without read");
  ////////////////////////////////////////////////////////////////////////////
  // status capture
  AST_FAULT_TRACK: assert property (@(posedge sys_clk) // [RL11]
    disable iff (reset) ##1 fault_reg == $past(fault_in))
    else $error("fault byte does not follow sources");
  AST_FAULT_RO: assert property (@(posedge sys_clk) // [RL14]
    disable iff (reset) reg_wr_en && reg_addr == 8'h78
    |=> fault_reg == $past(fault_in))
    else $error("fault byte written");
  ////////////////////////////////////////////////////////////////////////////
  // write path
  AST_SETPOINT_LOW_WR: assert property (@(posedge sys_clk) // [RL3]
    disable iff (reset) reg_wr_en && reg_addr == 8'h0C
    |=> output_setpoint[7:0] == $past(reg_wdata))
    else $error("setpoint low byte not applied");
  AST_SETPOINT_HIGH_WR: assert property (@(posedge sys_clk) // [RL3]
    disable iff (reset) reg_wr_en && reg_addr == 8'h0D
    |=> output_setpoint[11:8] == $past(reg_wdata[3:0]))
    else $error("setpoint high nibble not applied");
  AST_SETPOINT_HOLD: assert property (@(posedge sys_clk) // [RL3]
    disable iff (reset)
    !(reg_wr_en && (reg_addr == 8'h0C || reg_addr == 8'h0D))
    |=> $stable(output_setpoint))
    else $error("setpoint changed without write");
  AST_DISCHARGE: assert property (@(posedge sys_clk) // [RL15] [RL16]
    disable iff (reset) reg_wr_en && reg_addr == 8'h81
    |=> output_discharge_request == $past(reg_wdata[1])
    && power_stage_enable_b == $past(reg_wdata[0]))
    else $error("control write not applied");
  AST_ENABLE_HOLD: assert property (@(posedge sys_clk) // [RL16]
    disable iff (reset) !(reg_wr_en && reg_addr == 8'h81)
    |=> $stable(power_stage_enable_b))
    else $error("enable changed without write");
  AST_DISCH_HOLD: assert property (@(posedge sys_clk) // [RL15]
    disable iff (reset) !(reg_wr_en && reg_addr == 8'h81)
    |=> $stable(output_discharge_request))
    else $error("discharge changed without write");
endmodule : ccs_regs

//--- tb/ccs_host_model.sv
// Purpose: host model driving the byte register port of the bank
// Assumes: strobes change on the falling edge of sys_clk
// Notes: read answer awaited for a bounded number of cycles
`timescale 1ns/10ps
module ccs_host_model (
  input wire logic sys_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one byte write; strobe stays up so writes can follow back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
  endtask : wr
  // released bus: address and data toggle instead of holding
  task automatic idle();
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : idle
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end else begin
        @(negedge sys_clk);
      end
    end
  endtask : rd
endmodule : ccs_host_model

//--- tb/tb.sv
// Purpose: self-checking bench of the converter register bank
// Assumes: inputs change on the falling edge
// Notes: table of write/readback rows, then hand-written cases
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] r;
  } ccs_row_s;
  logic sys_clk, reset, wr_en, rd_en, cc, fdiv, rvalid, disch, en;
  logic [7:0] addr, wdata, rdata, ilim_code;
  logic [16:0] ilim_uv;
  logic [15:0] vout_mv;
  logic [11:0] setpoint;
  ccs_pkg::ccs_fault_s fault_in;
  int bad_count = 0;
  int comparisons = 0;
  ccs_row_s rows[7] = '{'{8'h0C, 8'hA5, 8'hA5}, '{8'h0D, 8'hF7, 8'h07},
    '{8'h81, 8'h01, 8'h01}, '{8'h21, 8'hFF, 8'h00}, '{8'h78, 8'hFF, 8'h00},
    '{8'h55, 8'hFF, 8'h00}, '{8'h81, 8'hFE, 8'h02}};
  logic [7:0] icode[6] = '{8'h01, 8'h10, 8'h8B, 8'h8C, 8'hC1, 8'hFF};
  int iuv[6] = '{500, 8000, 69500, 70000, 70000, 70000};

  ccs_host_model ccs_host_model_i (.sys_clk(sys_clk), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid));
  ccs_regs ccs_regs_i (.sys_clk(sys_clk), .reset(reset), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .current_limit_threshold(ilim_code), .feedback_divider_select(fdiv),
    .constant_current_active(cc), .fault_in(fault_in), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .output_discharge_request(disch),
    .power_stage_enable_b(en), .current_limit_threshold_uv(ilim_uv),
    .vout_target_mv(vout_mv), .output_setpoint(setpoint));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    ccs_host_model_i.rd(a, d, ok);
    if (!ok) begin
      bad_count++;
      $display("[ERR] rvalid expected 1 seen 0");
      results();
    end
    chk("rdata", {24'h0, d}, {24'h0, exp});
  endtask : rchk
  task automatic vchk(input logic fd, input logic [15:0] exp);
    fdiv = fd;
    repeat (3) @(negedge sys_clk);
    chk("vout_target", {16'h0, vout_mv}, {16'h0, exp});
  endtask : vchk
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    results();
  end
  initial begin
    reset = 1'b1;
    cc = 1'b0;
    fdiv = 1'b1;
    ilim_code = 8'h00;
    fault_in = 8'h00;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    chk("setpoint", {20'h0, setpoint}, 32'h0000_0258);
    chk("enable", {31'h0, en}, 32'h0000_0001);
    chk("discharge", {31'h0, disch}, 32'h0000_0000);
    rchk(8'h0C, 8'h58);
    rchk(8'h0D, 8'h02);
    rchk(8'h21, 8'h00);
    rchk(8'h78, 8'h00);
    rchk(8'h81, 8'h01);
    foreach (rows[i]) begin
      ccs_host_model_i.wr(rows[i].a, rows[i].w);
      ccs_host_model_i.idle();
      rchk(rows[i].a, rows[i].r);
    end
    chk("setpoint", {20'h0, setpoint}, 32'h0000_07A5);
    chk("discharge", {31'h0, disch}, 32'h0000_0001);
    chk("enable", {31'h0, en}, 32'h0000_0000);
    vchk(1'b1, 16'h98E4);
    ccs_host_model_i.wr(8'h0C, 8'h00);
    ccs_host_model_i.wr(8'h0D, 8'h00);
    ccs_host_model_i.idle();
    vchk(1'b1, 16'h0CE4);
    vchk(1'b0, 16'h03E8);
    ccs_host_model_i.wr(8'h0C, 8'hFF);
    ccs_host_model_i.wr(8'h0D, 8'hFF);
    ccs_host_model_i.idle();
    vchk(1'b0, 16'h9FF6);
    vchk(1'b1, 16'hBB80);
    ccs_host_model_i.wr(8'h0C, 8'hE8);
    ccs_host_model_i.wr(8'h0D, 8'h03);
    ccs_host_model_i.idle();
    vchk(1'b1, 16'h4E20);
    foreach (icode[i]) begin
      ilim_code = icode[i];
      repeat (3) @(negedge sys_clk);
      chk("ilim_uv", {15'h0, ilim_uv}, iuv[i]);
    end
    for (int i = 0; i < 8; i++) begin
      fault_in = 8'h01 << i;
      repeat (2) @(negedge sys_clk);
      rchk(8'h78, 8'h01 << i);
    end
    fault_in = 8'h00;
    cc = 1'b1;
    ccs_host_model_i.wr(8'h21, 8'h00);
    ccs_host_model_i.idle();
    rchk(8'h21, 8'h40);
    cc = 1'b0;
    repeat (2) @(negedge sys_clk);
    rchk(8'h21, 8'h00);
    ccs_host_model_i.wr(8'h81, 8'h02);
    ccs_host_model_i.wr(8'h0C, 8'h11);
    ccs_host_model_i.idle();
    reset = 1'b1;
    @(negedge sys_clk);
    reset = 1'b0;
    chk("setpoint", {20'h0, setpoint}, 32'h0000_0258);
    chk("enable", {31'h0, en}, 32'h0000_0001);
    chk("discharge", {31'h0, disch}, 32'h0000_0000);
    rchk(8'h81, 8'h01);
    rchk(8'h78, 8'h00);
    results();
  end
endmodule : tb
